// File: logic/lpwc_core.sv
// long pulse width capture: free-running timer, edge capture, overflow extension
`timescale 1ns/10ps
// Contract
// - after first edge, polarity inverts when auto reverse is set and capture flag sets before second edge
// - pulses of either polarity longer than one counter period measurable via the overflow count
// - counter latched into capture register on selected edge; difference gives low half
// - every rollover raises overflow event; overflows between edges are counted
// - overflow coinciding with an edge is attributed to the correct side
// - sequence arms first edge, then opposite edge when auto reverse is set, capturing at both
// - pulse shorter than the re-arm time is marked invalid
// - counter advances once per eight input clocks
//
// register map, word index on the plain port
//   0 control: bit0 edge polarity (1 rising), bit1 arm (write only), bit2 auto reverse
//   1 status, write one to clear: bit0 capture, bit1 overflow, bit2 done, bit3 lost
//   2 interrupt mask, same layout as status
//   3 last captured count
//   4 width: overflow count in the high half, count difference in the low half
//   5 overflows seen since the first edge
//   6 free-running counter
//
// measurement walk
//   write control with arm set; the sequencer waits for the first edge
//   first edge: count latched as start, capture flag set, polarity reversed if auto reverse is set
//   overflows between the first and second edge are counted, one per counter wrap
//   second edge: count latched, width formed, capture and done flags set
//   a second edge inside the re-arm window also sets the lost flag
//
// limitations
//   lost only marks a second edge that came too soon after the first;
//   a second edge missed altogether leaves the sequencer waiting for the next one
//   the width stays frozen while done is set, so software clears done first
//   the overflow count saturates nowhere; it wraps after 2^16 rollovers
module lpwc_core #(
  parameter int PRESCALE = lpwc_pkg::LPWC_PRESCALE,
  parameter int REARM_CYC = lpwc_pkg::LPWC_REARM_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic capture_input_pin,
  input wire lpwc_pkg::lpwc_bus_t bus,
  output logic [31:0] rdata,
  output logic irq,
  output logic pin_level
);
  import lpwc_pkg::*;

  // timer and prescaler
  logic [LPWC_CNT_W-1:0] count_q;
  logic [3:0] pre_q;
  logic tick;
  logic wrap;

  // pin sampling and edge choice
  logic pin_q;
  logic edge_hit;
  logic capture_edge_polarity;

  // software visible registers
  logic [2:0] ctrl_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [15:0] cap_q;
  logic [31:0] width_q;

  // measurement state
  logic [15:0] start_q;
  logic [15:0] ovf_cnt_q;
  logic [15:0] rearm_q;
  lpwc_state_t state_q;
  logic arm_pulse;
  logic ovf_early;
  logic [15:0] ovf_total;
  logic [15:0] cap_now;
  logic [3:0] stat_set;

  // write strobe aimed at one register word
  function automatic logic wr_hit(input lpwc_bus_t b, input logic [3:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // read multiplexer; unmapped words read as zero
  function automatic logic [31:0] rd_word(input logic [3:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      LPWC_ADDR_CTRL: v = {29'h0, ctrl_q};
      LPWC_ADDR_STAT: v = {28'h0, stat_q};
      LPWC_ADDR_MASK: v = {28'h0, mask_q};
      LPWC_ADDR_CAP: v = {16'h0, cap_q};
      LPWC_ADDR_WIDTH: v = width_q;
      LPWC_ADDR_OVF: v = {16'h0, ovf_cnt_q};
      LPWC_ADDR_COUNT: v = {16'h0, count_q};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // control decode; arm is an action, never stored
  assign capture_edge_polarity = ctrl_q[LPWC_CTRL_POL_BIT];
  assign arm_pulse = wr_hit(bus, LPWC_ADDR_CTRL) && bus.wdata[LPWC_CTRL_ARM_BIT];

  // prescaler, one tick every eight clocks
  assign tick = (pre_q == 4'(PRESCALE - 1));
  always_ff @(posedge ref_clk) begin
    if (srst || tick) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // free-running 16-bit timer
  assign wrap = tick && (count_q == 16'hFFFF);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_q <= LPWC_CNT_RST;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // edge detect on the chosen polarity; 1 selects rising
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= capture_input_pin;
    end
  end
  assign edge_hit = capture_edge_polarity ? (capture_input_pin && !pin_q)
                                          : (!capture_input_pin && pin_q);
  // level readable as a plain input, covers very short pulses
  assign pin_level = pin_q;

  // an overflow in the edge cycle happened before the latched value when the
  // counter reads FFFF and ticks in that cycle; the latched count already wrapped
  assign ovf_early = wrap;
  assign ovf_total = ovf_cnt_q + (ovf_early ? 16'h0001 : 16'h0000);

  // count as seen by an edge in this cycle; a wrap in the same cycle reads zero
  // so the edge and the overflow agree on which side of the edge the wrap lies
  assign cap_now = wrap ? 16'h0000 : count_q;

  // capture register latches the counter on each selected edge while not idle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cap_q <= LPWC_CNT_RST;
    end else if (edge_hit && state_q != LPWC_IDLE) begin
      cap_q <= cap_now;
    end
  end

  // measurement sequencer
  // an arm write restarts a measurement from any state, even mid pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= LPWC_IDLE;
    end else if (arm_pulse) begin
      state_q <= LPWC_WAIT_FIRST;
    end else begin
      unique case (state_q)
        LPWC_IDLE: begin
          state_q <= LPWC_IDLE;
        end
        LPWC_WAIT_FIRST: begin
          if (edge_hit) begin
            state_q <= LPWC_WAIT_SECOND;
          end
        end
        LPWC_WAIT_SECOND: begin
          if (edge_hit) begin
            state_q <= LPWC_IDLE;
          end
        end
        // the fourth code of the two state bits is never entered
        default: begin
          state_q <= LPWC_IDLE;
        end
      endcase
    end
  end

  // control: polarity, auto reverse; arm is a write-only action bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= LPWC_CTRL_RST;
    end else if (wr_hit(bus, LPWC_ADDR_CTRL)) begin
      ctrl_q <= {bus.wdata[LPWC_CTRL_AUTO_BIT], 1'b0, bus.wdata[LPWC_CTRL_POL_BIT]};
    end else if (edge_hit && state_q != LPWC_IDLE && ctrl_q[LPWC_CTRL_AUTO_BIT]) begin
      // hardware reverse removes the software re-arm gap
      ctrl_q[LPWC_CTRL_POL_BIT] <= !capture_edge_polarity;
    end
  end

  // start value, overflow accumulation between edges
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      start_q <= LPWC_CNT_RST;
      ovf_cnt_q <= 16'h0000;
    end else if (edge_hit && state_q == LPWC_WAIT_FIRST) begin
      start_q <= cap_now;
      ovf_cnt_q <= 16'h0000; // wrap in this cycle lies before the start
    end else if (state_q == LPWC_WAIT_SECOND && !edge_hit && wrap) begin
      ovf_cnt_q <= ovf_cnt_q + 16'h0001;
    end
  end

  // width: overflows high, difference low, borrow folds one overflow away
  // an end count below the start means one counted wrap is already in the
  // modulo difference, so it is taken back out of the high half
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      width_q <= 32'h0000_0000;
    end else if (edge_hit && state_q == LPWC_WAIT_SECOND && !stat_q[LPWC_ST_DONE_BIT]) begin
      width_q <= {ovf_total, 16'h0000} + 32'(cap_now - start_q)
                 - ((cap_now < start_q) ? 32'h0001_0000 : 32'h0);
    end
  end

  // re-arm timer, counts cycles since the first edge
  // saturates so a very long pulse never looks short again
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rearm_q <= 16'h0000;
    end else if (edge_hit && state_q == LPWC_WAIT_FIRST) begin
      rearm_q <= 16'h0000;
    end else if (rearm_q != 16'hFFFF) begin
      rearm_q <= rearm_q + 16'h0001;
    end
  end

  // status events; set beats the write-one clear
  // an event in the clearing cycle must not be lost to software
  always_comb begin
    stat_set = 4'h0;
    // every edge taken by the sequencer
    stat_set[LPWC_ST_CAP_BIT] = edge_hit && state_q != LPWC_IDLE;
    // every rollover, measuring or not
    stat_set[LPWC_ST_OVF_BIT] = wrap;
    // the closing edge of a measurement
    stat_set[LPWC_ST_DONE_BIT] = edge_hit && state_q == LPWC_WAIT_SECOND;
    // a second edge inside the re-arm window may be a missed one
    stat_set[LPWC_ST_LOST_BIT] = edge_hit && state_q == LPWC_WAIT_SECOND
                                 && rearm_q < 16'(REARM_CYC);
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stat_q <= LPWC_ST_RST;
    end else if (wr_hit(bus, LPWC_ADDR_STAT)) begin
      stat_q <= (stat_q & ~bus.wdata[LPWC_ST_W-1:0]) | stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mask_q <= LPWC_MASK_RST;
    end else if (wr_hit(bus, LPWC_ADDR_MASK)) begin
      mask_q <= bus.wdata[LPWC_ST_W-1:0];
    end
  end

  // level interrupt straight from registers, no extra delay
  assign irq = |(stat_q & mask_q);

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= rd_word(bus.addr);
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// File: inc/lpwc_pkg.sv
// package for the long pulse width capture block
package lpwc_pkg;
  // register word offsets on the plain port
  localparam logic [3:0] LPWC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] LPWC_ADDR_STAT = 4'h1;
  localparam logic [3:0] LPWC_ADDR_MASK = 4'h2;
  localparam logic [3:0] LPWC_ADDR_CAP = 4'h3;
  localparam logic [3:0] LPWC_ADDR_WIDTH = 4'h4;
  localparam logic [3:0] LPWC_ADDR_OVF = 4'h5;
  localparam logic [3:0] LPWC_ADDR_COUNT = 4'h6;
  // control fields
  localparam int LPWC_CTRL_POL_BIT = 0;
  localparam int LPWC_CTRL_ARM_BIT = 1;
  localparam int LPWC_CTRL_AUTO_BIT = 2;
  localparam logic [2:0] LPWC_CTRL_RST = 3'h0;
  // status / mask fields
  localparam int LPWC_ST_CAP_BIT = 0;
  localparam int LPWC_ST_OVF_BIT = 1;
  localparam int LPWC_ST_DONE_BIT = 2;
  localparam int LPWC_ST_LOST_BIT = 3;
  localparam int LPWC_ST_W = 4;
  localparam logic [3:0] LPWC_ST_RST = 4'h0;
  localparam logic [3:0] LPWC_MASK_RST = 4'h0;
  // timing: counter ticks once per eight input clocks
  localparam int LPWC_PRESCALE = 8;
  localparam int LPWC_CNT_W = 16;
  localparam logic [15:0] LPWC_CNT_RST = 16'h0000;
  // re-arm window in ns, a shorter pulse is flagged lost
  localparam int LPWC_REARM_NS = 20000;
  localparam int LPWC_CLK_NS = 50;
  localparam int LPWC_REARM_CYC = (LPWC_REARM_NS + LPWC_CLK_NS - 1) / LPWC_CLK_NS;
  // register bus carrier
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lpwc_bus_t;
  typedef enum logic [1:0] {LPWC_IDLE, LPWC_WAIT_FIRST, LPWC_WAIT_SECOND} lpwc_state_t;
endpackage

// File: bench/lpwc_core_sva.sv
// assertion checker for the long pulse width capture block
`timescale 1ns/10ps
module lpwc_core_sva #(
  parameter int PRESCALE = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic capture_input_pin,
  input wire lpwc_pkg::lpwc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic pin_level
);
  import lpwc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic mz_q;
  // tracks a cleared mask, so irq can be judged without a status read
  always_ff @(posedge ref_clk) begin
    if (srst) mz_q <= 1'b1;
    else if (bus.wr && bus.addr == LPWC_ADDR_MASK) mz_q <= bus.wdata[3:0] == 4'h0;
  end
  // register port answers
  sequence s_rdc; bus.rd && bus.addr == LPWC_ADDR_COUNT; endsequence
  property p_idle; !bus.rd |=> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_unmap; bus.rd && bus.addr > LPWC_ADDR_COUNT |=> rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_arm; bus.rd && bus.addr == LPWC_ADDR_CTRL |=> !rdata[LPWC_CTRL_ARM_BIT]; endproperty
  a_arm: assert property (p_arm) else $error("arm bit reads one");
  property p_mrb; bus.wr && bus.addr == LPWC_ADDR_MASK ##2 bus.rd && bus.addr == LPWC_ADDR_MASK
    |=> rdata[3:0] == $past(bus.wdata[3:0], 3); endproperty
  a_mrb: assert property (p_mrb) else $error("mask readback");
  // counter rate over eight clocks
  property p_tick; s_rdc ##8 s_rdc |=> rdata[15:0] == $past(rdata[15:0], 8) + 16'(8 / PRESCALE);
    endproperty
  a_tick: assert property (p_tick) else $error("counter rate");
  // interrupt, reset and pin copy
  property p_mask; mz_q |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_rst; $fell(srst) |-> rdata == 32'h0 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_pin; 1 |=> pin_level == $past(capture_input_pin); endproperty
  a_pin: assert property (p_pin) else $error("pin copy");
endmodule
bind lpwc_core lpwc_core_sva #(.PRESCALE(PRESCALE)) u_sva (.ref_clk(ref_clk), .srst(srst),
  .capture_input_pin(capture_input_pin), .bus(bus), .rdata(rdata), .irq(irq),
  .pin_level(pin_level));

// File: bench/lpwc_pulse_src.sv
// pulse source on the capture pin
`timescale 1ns/10ps
module lpwc_pulse_src (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic [31:0] len,
  output logic pin
);
  logic [31:0] left_q = 32'h0;
  // a fire gives a high pulse of len clocks, the pin rests low between pulses
  always_ff @(posedge ref_clk) begin
    if (fire) left_q <= len;
    else if (left_q != 32'h0) left_q <= left_q - 32'h1;
  end
  assign pin = left_q != 32'h0;
endmodule

// File: bench/testbench.sv
// testbench for the long pulse width capture block
`timescale 1ns/10ps
module testbench;
  import lpwc_pkg::*;
  logic ref_clk, srst, pin, irq, pin_level, fire;
  logic [31:0] rdata, len, d, w, s;
  lpwc_bus_t bus;
  int num_errors = 0;
  int samples_checked = 0;
  int i;
  // short counts keep a rollover inside the run
  lpwc_core #(.PRESCALE(1), .REARM_CYC(40)) dut (.ref_clk(ref_clk), .srst(srst),
    .capture_input_pin(pin), .bus(bus), .rdata(rdata), .irq(irq), .pin_level(pin_level));
  lpwc_pulse_src src (.ref_clk(ref_clk), .fire(fire), .len(len), .pin(pin));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // one strobe cycle, read data taken the cycle after
  task automatic acc(input logic [3:0] a, input logic [31:0] v, input logic wr);
    @(posedge ref_clk) bus <= '{a, v, wr, !wr};
    @(posedge ref_clk) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input string n, input logic [3:0] a, input logic [31:0] e);
    acc(a, 32'h0, 1'b0);
    chk(n, d, e);
  endtask
  task automatic pulse(input logic [31:0] n);
    @(posedge ref_clk);
    len <= n;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask
  // bounded poll; running out counts a done failure and ends the run
  task automatic wait_done();
    d = 32'h0;
    for (i = 0; i < 40000 && !d[LPWC_ST_DONE_BIT]; i++) acc(LPWC_ADDR_STAT, 32'h0, 1'b0);
    if (!d[LPWC_ST_DONE_BIT]) begin
      num_errors++;
      $display("[FAIL] done expected 1 seen 0");
      close_out();
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    bus = '0;
    fire = 1'b0;
    len = 32'h0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rc("unmapped", 4'h9, 32'h0);
    acc(LPWC_ADDR_COUNT, 32'h0, 1'b0);
    w = d + 32'h8;
    repeat (6) @(posedge ref_clk);
    rc("tick", LPWC_ADDR_COUNT, w);
    acc(LPWC_ADDR_MASK, 32'hF, 1'b1);
    acc(LPWC_ADDR_CTRL, 32'h7, 1'b1);
    rc("armed", LPWC_ADDR_CTRL, 32'h5);
    pulse(32'd70000);
    repeat (8) @(posedge ref_clk);
    rc("flip", LPWC_ADDR_CTRL, 32'h4);
    rc("first", LPWC_ADDR_STAT, 32'h1);
    acc(LPWC_ADDR_CAP, 32'h0, 1'b0);
    s = d;
    wait_done();
    rc("long stat", LPWC_ADDR_STAT, 32'h7);
    chk("irq", {31'h0, irq}, 32'h1);
    rc("width", LPWC_ADDR_WIDTH, 32'h0001_1170);
    acc(LPWC_ADDR_CAP, 32'h0, 1'b0);
    chk("cap diff", (d - s) & 32'h0000_FFFF, 32'h0000_1170);
    rc("ovf", LPWC_ADDR_OVF, 32'h1);
    pulse(32'd50);
    repeat (60) @(posedge ref_clk);
    rc("held", LPWC_ADDR_WIDTH, 32'h0001_1170);
    acc(LPWC_ADDR_STAT, 32'hF, 1'b1);
    chk("irq low", {31'h0, irq}, 32'h0);
    acc(LPWC_ADDR_CTRL, 32'h7, 1'b1);
    pulse(32'd20);
    wait_done();
    rc("short stat", LPWC_ADDR_STAT, 32'hD);
    acc(LPWC_ADDR_MASK, 32'h0, 1'b1);
    rc("mask", LPWC_ADDR_MASK, 32'h0);
    chk("masked", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule
